/* File: include/adc_readout_pkg.sv */
/*
  Shared constants for the parallel sample readout of the converter:
  sample framing, code limits, pin vector layout, register map and the
  settling count. Assumes a single 100 MHz converter clock.
*/
`default_nettype none

package adc_readout_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_MIN_NS = 50;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] DECIM_RATIO = 6'h20;
  localparam logic [4:0] PHASE_LAST = 5'h1F;
  localparam logic [4:0] PHASE_RISE = 5'h0F;
  localparam logic [4:0] HALF_PERIOD = 5'h10;
  localparam logic [5:0] SETTLE_PERIODS = 6'h2E;

  // ****************************************************************
  // sample format
  // ****************************************************************
  localparam int DATA_W = 18;
  localparam logic [17:0] CODE_MAX = 18'h07FFF;
  localparam logic [17:0] CODE_MIN = 18'h38000;
  localparam logic [6:0] ONES_MID = 7'h10;
  localparam int CODE_SHIFT = 11;

  // ****************************************************************
  // synchronised pin vector
  // ****************************************************************
  localparam int PIN_W = 8;
  localparam int PIN_CS = 0;
  localparam int PIN_RD = 1;
  localparam int PIN_PD = 2;
  localparam int PIN_REF = 3;
  localparam int PIN_OVR = 4;
  localparam int PIN_DEPTH = 5;
  localparam logic [7:0] PIN_RESET = 8'h07;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_EN = 4'h1;
  localparam logic [3:0] REG_IRQ_CLR = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  localparam logic [3:0] REG_STATE = 4'h4;
  localparam logic [3:0] REG_SAMPLE = 4'h5;
  localparam int EV_W = 3;
  localparam int EV_SAMPLE = 0;
  localparam int EV_OVR = 1;
  localparam int EV_SETTLED = 2;
  localparam int CTRL_HALT = 0;
  localparam logic [2:0] EV_RESET = 3'h0;

endpackage : adc_readout_pkg

`default_nettype wire

/* File: design/adc_parallel_readout.sv */
/*
  Parallel readout side of an 18-bit delta-sigma converter: decimates the
  one-bit modulator stream, frames samples with an active-low ready strobe
  and presents them on a gated 18-bit bus, with status pins and a small
  register port. Assumes the modulator runs on mclk and that every control
  pin is asynchronous to it.
*/
// The strobed register port and the placing of the registers were left to the implementer.
// Function
// [RQ1] unbuffered: ready strobe 16 clocks high, 16 clocks low, forever
// [RQ2] ready strobe active low, moves on a rising edge; fall = new sample
// [RQ3] bus driven only while chip select and read strobe are both low
// [RQ4] sample is an 18-bit word, bit 17 most significant
// [RQ5] decimation filter held cleared while reset is low
// [RQ6] during reset, ready strobe high and every data bit low
// [RQ7] controller keeps reset low at least 50 ns
// [RQ8] first 46 ready periods after reset are not yet settled
// [RQ9] over-range output high while input exceeds range, else low
// [RQ10] power-down low shuts everything down; high resumes operation
// [RQ11] ref-enable low picks internal reference; pulled low by default
// [RQ12] three buffer depth select inputs read, bit 2 most significant
// [RQ13] two's complement codes, positive full scale 7FFF, negative 8000
// [RQ14] decimate by 32, one sample every 32 clocks
// [RQ15] host captures the word at each ready fall in unbuffered mode
`timescale 1ns/10ps
`default_nettype none

module adc_parallel_readout (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // modulator stream, same clock
  input wire logic mod_bit,
  // asynchronous control pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic power_down_n,
  input wire logic internal_ref_enable_n,
  input wire logic analog_over_range,
  input wire logic [2:0] buffer_depth_select,
  // sample outputs
  output logic sample_ready_n,
  output logic [17:0] dout_o,
  output logic dout_oe,
  output logic over_range_flag,
  // analog controls
  output logic ref_internal_sel,
  output logic analog_on,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic irq
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // ones count of one frame to a saturated two's complement code
  function automatic logic [17:0] ones_to_code(input logic [5:0] ones);
    logic signed [6:0] diff;
    logic signed [17:0] wide;
    diff = signed'({1'b0, ones}) - signed'(adc_readout_pkg::ONES_MID);
    wide = 18'(signed'(diff)) <<< adc_readout_pkg::CODE_SHIFT;
    if (diff >= signed'(adc_readout_pkg::ONES_MID)) begin
      ones_to_code = adc_readout_pkg::CODE_MAX;
    end else begin
      ones_to_code = wide;
    end
  endfunction : ones_to_code

  // a pin level is accepted once the 2nd and 3rd stages agree
  function automatic logic [7:0] agree(input logic [7:0] prev,
                                       input logic [7:0] s2,
                                       input logic [7:0] s3);
    agree = (s2 & s3) | (prev & (s2 ^ s3));
  endfunction : agree

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [7:0] pin_raw;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] sync3_q;
  logic [7:0] pin_q;

  assign pin_raw = {buffer_depth_select, analog_over_range,
                    internal_ref_enable_n, power_down_n, rd_n, cs_n};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_q <= adc_readout_pkg::PIN_RESET;
      sync2_q <= adc_readout_pkg::PIN_RESET;
      sync3_q <= adc_readout_pkg::PIN_RESET;
      pin_q <= adc_readout_pkg::PIN_RESET;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= agree(pin_q, sync2_q, sync3_q);
    end
  end

  logic cs_ok;
  logic rd_ok;
  logic pd_ok;
  logic ref_n_ok;
  logic ovr_ok;
  logic [2:0] depth_ok;
  logic halt_q;
  logic run;

  assign cs_ok = pin_q[adc_readout_pkg::PIN_CS];
  assign rd_ok = pin_q[adc_readout_pkg::PIN_RD];
  assign pd_ok = pin_q[adc_readout_pkg::PIN_PD];
  assign ref_n_ok = pin_q[adc_readout_pkg::PIN_REF];
  assign ovr_ok = pin_q[adc_readout_pkg::PIN_OVR];
  assign depth_ok = pin_q[adc_readout_pkg::PIN_DEPTH +: 3]; // RQ12
  // power-down pin or the software halt both stop the converter
  assign run = pd_ok && !halt_q; // RQ10

  // ****************************************************************
  // decimation filter and framing
  // ****************************************************************
  logic [4:0] phase_q;
  logic [5:0] ones_q;
  logic [5:0] ones_d;

  assign ones_d = ones_q + {5'h00, mod_bit};

  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin // RQ5 RQ10
      phase_q <= 5'h00;
      ones_q <= 6'h00;
    end else begin
      phase_q <= phase_q + 5'h01; // RQ14
      if (phase_q == adc_readout_pkg::PHASE_LAST) begin
        ones_q <= 6'h00;
      end else begin
        ones_q <= ones_d;
      end
    end
  end

  // strobe falls with the new word and rises half a frame later
  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin // RQ6
      sample_ready_n <= 1'b1;
      dout_o <= 18'h00000;
    end else if (phase_q == adc_readout_pkg::PHASE_LAST) begin
      sample_ready_n <= 1'b0; // RQ1 RQ2
      dout_o <= ones_to_code(ones_d); // RQ4 RQ13
    end else if (phase_q == adc_readout_pkg::PHASE_RISE) begin
      sample_ready_n <= 1'b1; // RQ1
    end
  end

  // ****************************************************************
  // bus gating and status pins
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dout_oe <= 1'b0;
      over_range_flag <= 1'b0;
      ref_internal_sel <= 1'b0;
      analog_on <= 1'b0;
    end else begin
      dout_oe <= run && !cs_ok && !rd_ok; // RQ3
      over_range_flag <= run && ovr_ok; // RQ9
      // pin pulled low by default, so internal is the idle choice
      ref_internal_sel <= run && !ref_n_ok; // RQ11
      analog_on <= run; // RQ10
    end
  end

  // ****************************************************************
  // settling count
  // ****************************************************************
  logic [5:0] settle_q;
  logic settled_q;
  logic ready_fall;
  logic ovr_prev_q;

  assign ready_fall = run && (phase_q == adc_readout_pkg::PHASE_LAST);

  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      settle_q <= 6'h00;
      settled_q <= 1'b0;
    end else if (ready_fall && !settled_q) begin
      settle_q <= settle_q + 6'h01; // RQ8
      settled_q <= (settle_q + 6'h01) == adc_readout_pkg::SETTLE_PERIODS;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovr_prev_q <= 1'b0;
    end else begin
      ovr_prev_q <= over_range_flag;
    end
  end

  // ****************************************************************
  // registers and interrupt
  // ****************************************************************
  logic [2:0] ev_set;
  logic [2:0] status_q;
  logic [2:0] irq_en_q;
  logic [2:0] clr;
  logic wr_hit_clr;

  assign ev_set[adc_readout_pkg::EV_SAMPLE] = ready_fall;
  assign ev_set[adc_readout_pkg::EV_OVR] = over_range_flag && !ovr_prev_q;
  assign ev_set[adc_readout_pkg::EV_SETTLED] = ready_fall && !settled_q &&
    ((settle_q + 6'h01) == adc_readout_pkg::SETTLE_PERIODS);
  assign wr_hit_clr = reg_wr && (reg_addr == adc_readout_pkg::REG_IRQ_CLR);
  assign clr = wr_hit_clr ? reg_wdata[2:0] : 3'h0;

  // a new event in the clear cycle survives the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_q <= adc_readout_pkg::EV_RESET;
    end else begin
      status_q <= (status_q & ~clr) | ev_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_en_q <= adc_readout_pkg::EV_RESET;
      halt_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == adc_readout_pkg::REG_IRQ_EN) begin
        irq_en_q <= reg_wdata[2:0];
      end
      if (reg_addr == adc_readout_pkg::REG_CTRL) begin
        halt_q <= reg_wdata[adc_readout_pkg::CTRL_HALT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_q & ~clr) | ev_set) & irq_en_q);
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n || !reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else begin
      unique case (reg_addr)
        adc_readout_pkg::REG_STATUS: reg_rdata <= {29'h0, status_q};
        adc_readout_pkg::REG_IRQ_EN: reg_rdata <= {29'h0, irq_en_q};
        adc_readout_pkg::REG_CTRL: reg_rdata <= {31'h0, halt_q};
        adc_readout_pkg::REG_STATE: reg_rdata <= {24'h0, depth_ok,
          dout_oe, ref_internal_sel, over_range_flag, run, settled_q};
        adc_readout_pkg::REG_SAMPLE: reg_rdata <= {14'h0, dout_o};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic [4:0] lvl_cnt_q;
  logic lvl_seen_q;

  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      lvl_cnt_q <= 5'h01;
      lvl_seen_q <= 1'b0;
    end else if (sample_ready_n != $past(sample_ready_n)) begin
      lvl_cnt_q <= 5'h01;
      lvl_seen_q <= 1'b1;
    end else begin
      lvl_cnt_q <= lvl_cnt_q + 5'h01;
    end
  end

  sequence s_word_loaded;
    !sample_ready_n && $changed(dout_o);
  endsequence

  sequence s_held_low;
    !sample_ready_n[*8];
  endsequence

  ready_half_period_a: assert property ( // RQ1
    @(posedge mclk) disable iff (!rst_n || !run)
    (lvl_seen_q && $changed(sample_ready_n))
      |-> lvl_cnt_q == adc_readout_pkg::HALF_PERIOD)
    else $error("ready strobe half period is not 16 clocks");

  word_at_fall_a: assert property ( // RQ2
    @(posedge mclk) disable iff (!rst_n || !run)
    $changed(dout_o) |-> $fell(sample_ready_n))
    else $error("data word changed away from a ready fall");

  low_then_rise_a: assert property ( // RQ1
    @(posedge mclk) disable iff (!rst_n || !run)
    $fell(sample_ready_n) |-> s_held_low ##1 s_held_low ##1 sample_ready_n)
    else $error("ready strobe did not rise 16 clocks after falling");

  bus_gate_a: assert property ( // RQ3
    @(posedge mclk) disable iff (!rst_n)
    (cs_ok || rd_ok) |=> !dout_oe)
    else $error("bus driven while select or read is high");

  reset_outputs_a: assert property ( // RQ6
    @(posedge mclk) disable iff (1'b0)
    !rst_n |=> (sample_ready_n && dout_o == 18'h00000 && !dout_oe))
    else $error("reset did not force strobe high and data low");

  filter_cleared_a: assert property ( // RQ5
    @(posedge mclk) disable iff (1'b0)
    !rst_n |=> (ones_q == 6'h00 && phase_q == 5'h00))
    else $error("decimation filter not cleared under reset");

  settle_count_a: assert property ( // RQ8
    @(posedge mclk) disable iff (!rst_n || !run)
    $rose(settled_q) |-> settle_q == adc_readout_pkg::SETTLE_PERIODS)
    else $error("settled flag not after 46 ready periods");

  over_range_a: assert property ( // RQ9
    @(posedge mclk) disable iff (!rst_n)
    (run && ovr_ok) |=> over_range_flag ##0 $past(ovr_ok, 1))
    else $error("over-range input not reflected on the flag");

  power_down_a: assert property ( // RQ10
    @(posedge mclk) disable iff (!rst_n)
    !pd_ok |=> (sample_ready_n && !analog_on && !dout_oe))
    else $error("power-down did not stop the converter");

  ref_select_a: assert property ( // RQ11
    @(posedge mclk) disable iff (!rst_n)
    (run && !ref_n_ok) |=> ref_internal_sel)
    else $error("internal reference not selected");

  code_range_a: assert property ( // RQ13
    @(posedge mclk) disable iff (!rst_n)
    s_word_loaded |-> (dout_o[17:15] == 3'h0 || dout_o[17:15] == 3'h7))
    else $error("sample code outside the 16-bit full scale");

endmodule : adc_parallel_readout

`default_nettype wire

/* File: tb/host_reader_model.sv */
/*
  Host-side reader model: selects the bus on request and captures the
  word at each falling edge of the ready strobe while the bus is driven.
  Assumes the readout block drives its outputs from mclk flops.
*/
`timescale 1ns/10ps
`default_nettype none

module host_reader_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // readout pins
  input wire logic sample_ready_n,
  input wire logic [17:0] dout_o,
  input wire logic dout_oe,
  output logic cs_n,
  output logic rd_n,
  // bench side
  input wire logic read_en,
  output logic [17:0] word_q
);
  logic ready_q;

  // chip select leads the read strobe by one clock
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_n <= 1'b1;
      rd_n <= 1'b1;
    end else begin
      cs_n <= ~read_en;
      rd_n <= ~(read_en & ~cs_n);
    end
  end

  // capture on the strobe fall; a word with the bus released is not taken
  always_ff @(posedge mclk) begin
    ready_q <= sample_ready_n;
    if (!rst_n)
      word_q <= 18'h00000;
    else if (ready_q && !sample_ready_n && dout_oe)
      word_q <= dout_o;
  end
endmodule : host_reader_model

`default_nettype wire

/* File: tb/test_adc_parallel_readout.sv */
/*
  Self-checking bench for the parallel readout block.
  Assumes one 100 MHz clock and the host reader model on the bus pins.
*/
`timescale 1ns/10ps
`default_nettype none

module test_adc_parallel_readout;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic mod_bit = 1'b1;
  logic power_down_n = 1'b1;
  logic internal_ref_enable_n = 1'b0;
  logic analog_over_range = 1'b0;
  logic [2:0] buffer_depth_select = 3'h5;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic read_en = 1'b0;
  logic cs_n, rd_n, sample_ready_n, dout_oe, over_range_flag;
  logic ref_internal_sel, analog_on, irq;
  logic [17:0] dout_o, word_q;
  logic [31:0] reg_rdata, rd_q;
  int num_errors = 0;
  int n_tests = 0;

  always #5 mclk = ~mclk;

  adc_parallel_readout dut_u (.mclk(mclk), .rst_n(rst_n), .mod_bit(mod_bit),
    .cs_n(cs_n), .rd_n(rd_n), .power_down_n(power_down_n),
    .internal_ref_enable_n(internal_ref_enable_n),
    .analog_over_range(analog_over_range),
    .buffer_depth_select(buffer_depth_select),
    .sample_ready_n(sample_ready_n), .dout_o(dout_o), .dout_oe(dout_oe),
    .over_range_flag(over_range_flag), .ref_internal_sel(ref_internal_sel),
    .analog_on(analog_on), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  host_reader_model host_u (.mclk(mclk), .rst_n(rst_n),
    .sample_ready_n(sample_ready_n), .dout_o(dout_o), .dout_oe(dout_oe),
    .cs_n(cs_n), .rd_n(rd_n), .read_en(read_en), .word_q(word_q));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask : reg_read

  // bounded: a strobe that stops framing ends the run
  task automatic wait_fall;
    int i;
    i = 0;
    while (sample_ready_n !== 1'b1 && i < 80) begin
      step(1);
      i++;
    end
    while (sample_ready_n !== 1'b0 && i < 80) begin
      step(1);
      i++;
    end
    if (i >= 80) begin
      num_errors++;
      $display("mismatch wait_fall expected fall seen none");
      results();
    end
  endtask : wait_fall

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    step(2);
    check("ready_in_reset", sample_ready_n, 1'b1);
    check("dout_in_reset", dout_o, 18'h00000);
    step(16);
    @(posedge mclk);
    rst_n <= 1'b1;
    $display("done reset");
  endtask : t_reset

  task automatic t_settle;
    repeat (45) wait_fall();
    reg_read(adc_readout_pkg::REG_STATE);
    check("not_settled", rd_q[0], 1'b0);
    wait_fall();
    step(3);
    reg_read(adc_readout_pkg::REG_STATE);
    check("settled", rd_q[0], 1'b1);
    reg_read(adc_readout_pkg::REG_STATUS);
    check("status_settled", rd_q[2], 1'b1);
    $display("done settle");
  endtask : t_settle

  task automatic t_frame;
    int n;
    wait_fall();
    for (n = 0; sample_ready_n === 1'b0 && n < 40; n++) step(1);
    check("low_width", n, 16);
    for (n = 0; sample_ready_n === 1'b1 && n < 40; n++) step(1);
    check("period", n + 16, 32);
    $display("done frame");
  endtask : t_frame

  task automatic t_codes;
    @(posedge mclk);
    read_en <= 1'b1;
    mod_bit <= 1'b1;
    repeat (2) wait_fall();
    check("code_max", dout_o, adc_readout_pkg::CODE_MAX);
    step(1);
    check("host_word", word_q, 18'h07FFF);
    @(posedge mclk);
    mod_bit <= 1'b0;
    repeat (2) wait_fall();
    check("code_min", dout_o, 18'h38000);
    step(1);
    check("host_word_min", word_q, 18'h38000);
    $display("done codes");
  endtask : t_codes

  task automatic t_gate;
    @(posedge mclk);
    read_en <= 1'b0;
    step(8);
    check("bus_off", dout_oe, 1'b0);
    @(posedge mclk);
    read_en <= 1'b1;
    step(8);
    check("bus_on", dout_oe, 1'b1);
    $display("done gate");
  endtask : t_gate

  task automatic t_over;
    reg_write(adc_readout_pkg::REG_IRQ_EN, 32'h0);
    analog_over_range <= 1'b1;
    step(8);
    check("flag_high", over_range_flag, 1'b1);
    check("irq_masked", irq, 1'b0);
    reg_read(adc_readout_pkg::REG_STATUS);
    check("status_ovr", rd_q[1], 1'b1);
    reg_write(adc_readout_pkg::REG_IRQ_EN, 32'h2);
    step(3);
    check("irq_on", irq, 1'b1);
    reg_read(adc_readout_pkg::REG_IRQ_EN);
    check("irq_en_back", rd_q, 32'h00000002);
    reg_write(adc_readout_pkg::REG_IRQ_CLR, 32'h2);
    step(3);
    check("irq_cleared", irq, 1'b0);
    @(posedge mclk);
    analog_over_range <= 1'b0;
    step(8);
    check("flag_low", over_range_flag, 1'b0);
    reg_read(4'hF);
    check("unmapped", rd_q, 32'h0);
    $display("done over_range");
  endtask : t_over

  task automatic t_power;
    reg_read(adc_readout_pkg::REG_STATE);
    check("depth", rd_q[7:5], 3'h5);
    check("ref_int", ref_internal_sel, 1'b1);
    @(posedge mclk);
    internal_ref_enable_n <= 1'b1;
    power_down_n <= 1'b0;
    step(40);
    check("pd_ready", sample_ready_n, 1'b1);
    check("pd_dout", dout_o, 18'h00000);
    check("pd_oe", dout_oe, 1'b0);
    check("pd_on", analog_on, 1'b0);
    check("ref_ext", ref_internal_sel, 1'b0);
    @(posedge mclk);
    mod_bit <= 1'b1;
    power_down_n <= 1'b1;
    wait_fall();
    check("resume_code", dout_o, 18'h07FFF);
    reg_read(adc_readout_pkg::REG_SAMPLE);
    check("sample_reg", rd_q, 32'h00007FFF);
    reg_write(adc_readout_pkg::REG_CTRL, 32'h00000001);
    step(3);
    check("halt_on", analog_on, 1'b0);
    check("halt_ready", sample_ready_n, 1'b1);
    reg_read(adc_readout_pkg::REG_CTRL);
    check("halt_back", rd_q, 32'h00000001);
    reg_write(adc_readout_pkg::REG_CTRL, 32'h00000000);
    $display("done power");
  endtask : t_power

  initial begin
    t_reset();
    t_settle();
    t_frame();
    t_codes();
    t_gate();
    t_over();
    t_power();
    wait_fall();
    step(3);
    t_reset();
    results();
  end
endmodule : test_adc_parallel_readout

`default_nettype wire
